/* File: logic/exord_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// - on take: save state, enter supervisor, fetch from exception vector
// - exceptions taken strictly in program order
// - instruction fault waits for older instructions and their faults
// - async precise waits for completion slot and empty store queue
// - complete means committed to architected registers
// - several conditions of one instruction taken one after another
// - only one exception being taken at once, except reset or machine check
// - precise faults save faulting address and block it and younger ones
// - imprecise float modes still report floating faults precisely
// - maskable async interrupts deferred until next instruction completes
// - with empty units, async taken once restart address known
// - reset and machine check are nonmaskable imprecise exceptions
// - recoverable bit reported from saved machine state, forced off for reset and machine check
// - bus error, parity errors or request raise machine check
// - config bits 0, 2, 3 gate request, address and data parity
// - transfer error machine check never masked
// - machine check cause recorded in a cause status register
// - software enables turn exception sources on or off
// - soft or hard reset vectors to offset 00100
// - machine check vectors to offset 00200
module exord_ctrl #(
    parameter int ADDR_W = exord_pkg::ADDR_W,
    parameter int MSR_W  = exord_pkg::MSR_W
) (
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    input  wire logic              soft_reset_in,
    input  wire logic              hard_reset_in,
    input  wire logic              bus_transfer_error_in,
    input  wire logic              address_parity_error_in,
    input  wire logic              data_parity_error_in,
    input  wire logic              machine_check_request_in,
    input  wire logic              ext_irq_in,
    input  wire logic              system_management_irq_in,
    input  wire logic              decrementer_irq_in,
    input  wire logic [3:0]        hw_config_reg_in,
    input  wire logic [2:0]        src_enable_in,
    input  wire logic              fp_imprecise_mode_in,
    input  wire logic              cmpl_valid_in,
    input  wire logic              cmpl_committed_in,
    input  wire logic              cmpl_fault_in,
    input  wire logic [ADDR_W-1:0] cmpl_addr_in,
    input  wire logic [ADDR_W-1:0] cmpl_fault_vec_in,
    input  wire logic              cmpl_more_faults_in,
    input  wire logic              cmpl_trap_in,
    input  wire logic [ADDR_W-1:0] cmpl_next_addr_in,
    input  wire logic              older_pending_in,
    input  wire logic              units_empty_in,
    input  wire logic              restart_known_in,
    input  wire logic [ADDR_W-1:0] restart_addr_in,
    input  wire logic              store_queue_empty_in,
    input  wire logic              handler_done_in,
    input  wire logic              msr_write_in,
    input  wire logic [MSR_W-1:0]  msr_wdata_in,
    output logic                   cmpl_accept_out,
    output logic                   flush_younger_out,
    output logic                   fetch_redirect_out,
    output logic      [ADDR_W-1:0] fetch_addr_out,
    output logic      [ADDR_W-1:0] save_restore_addr_reg_out,
    output logic      [MSR_W-1:0]  save_restore_state_reg_out,
    output logic      [MSR_W-1:0]  msr_out,
    output logic      [3:0]        mcheck_cause_out,
    output logic                   recoverable_interrupt_bit_out,
    output logic                   busy_out
);
    logic [8:0] sync_lvl;
    logic [8:0] sync_prev_q;
    logic       rst_req_q;
    logic       mc_req_q;
    logic       ext_pend_q;
    logic       decr_pend_q;
    logic       smi_pend_q;
    logic [3:0] mc_src;
    logic       mc_any;
    logic [3:0] mc_prev;
    logic [8:0] sync_rise;
    logic       rst_rise;
    exord_pkg::exord_state_t state_q;
    exord_pkg::exord_kind_t  kind_q;
    exord_pkg::exord_kind_t  take_kind;
    logic [ADDR_W-1:0] take_vec;
    logic [ADDR_W-1:0] take_addr;
    logic              take_now;
    logic              sync_fault;
    logic              async_ok;
    logic              async_any;
    logic              msr_ee;

    exord_sync #(
        .WIDTH (9)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .async_in   ({soft_reset_in, hard_reset_in, bus_transfer_error_in,
                      address_parity_error_in, data_parity_error_in,
                      machine_check_request_in, ext_irq_in,
                      system_management_irq_in, decrementer_irq_in}),
        .level_out  (sync_lvl)
    );

    assign msr_ee = msr_out[exord_pkg::MSR_EE];
    assign mc_src[exord_pkg::MC_TEA] = sync_lvl[6];
    assign mc_src[exord_pkg::MC_MCP] = sync_lvl[3] & hw_config_reg_in[exord_pkg::HWC_MCP_EN];
    assign mc_src[exord_pkg::MC_APE] = sync_lvl[5] & hw_config_reg_in[exord_pkg::HWC_APE_EN];
    assign mc_src[exord_pkg::MC_DPE] = sync_lvl[4] & hw_config_reg_in[exord_pkg::HWC_DPE_EN];
    assign sync_rise = sync_lvl & ~sync_prev_q;
    assign rst_rise  = sync_rise[8] | sync_rise[7];
    assign mc_prev[exord_pkg::MC_TEA] = sync_prev_q[6];
    assign mc_prev[exord_pkg::MC_MCP] = sync_prev_q[3];
    assign mc_prev[exord_pkg::MC_APE] = sync_prev_q[5];
    assign mc_prev[exord_pkg::MC_DPE] = sync_prev_q[4];
    // a source counts on the rising edge of its raw level while its gate is on
    assign mc_any = |(mc_src & ~mc_prev);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_prev_q <= '0;
        end else begin
            sync_prev_q <= sync_lvl;
        end
    end

    // nonmaskable requests, set wins over the clear at take
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rst_req_q <= 1'b0;
        end else if (rst_rise) begin
            rst_req_q <= 1'b1;
        end else if (take_now && take_kind == exord_pkg::EXORD_K_RESET) begin
            rst_req_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mc_req_q <= 1'b0;
        end else if (mc_any) begin
            mc_req_q <= 1'b1;
        end else if (take_now && take_kind == exord_pkg::EXORD_K_MC) begin
            mc_req_q <= 1'b0;
        end
    end

    // cause bits stick until the handler returns, a new cause wins
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mcheck_cause_out <= 4'h0;
        end else if (mc_any) begin
            mcheck_cause_out <= mcheck_cause_out | mc_src;
        end else if (handler_done_in) begin
            mcheck_cause_out <= 4'h0;
        end
    end

    // maskable async requests, set on a rising edge, pending until taken
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ext_pend_q  <= 1'b0;
            decr_pend_q <= 1'b0;
            smi_pend_q  <= 1'b0;
        end else begin
            if (sync_rise[2] & src_enable_in[0]) begin
                ext_pend_q <= 1'b1;
            end else if (take_now && take_kind == exord_pkg::EXORD_K_EXT) begin
                ext_pend_q <= 1'b0;
            end
            if (sync_rise[1] & src_enable_in[2]) begin
                smi_pend_q <= 1'b1;
            end else if (take_now && take_kind == exord_pkg::EXORD_K_SMI) begin
                smi_pend_q <= 1'b0;
            end
            if (sync_rise[0] & src_enable_in[1]) begin
                decr_pend_q <= 1'b1;
            end else if (take_now && take_kind == exord_pkg::EXORD_K_DECR) begin
                decr_pend_q <= 1'b0;
            end
        end
    end

    // completion acceptance, only committed results count
    assign sync_fault = cmpl_valid_in & cmpl_fault_in & ~older_pending_in;
    assign cmpl_accept_out = cmpl_valid_in & cmpl_committed_in & ~cmpl_fault_in
                             & (state_q == exord_pkg::EXORD_RUN) & ~rst_req_q & ~mc_req_q;
    assign async_any = ext_pend_q | decr_pend_q | smi_pend_q;
    assign async_ok = msr_ee & store_queue_empty_in
                      & ((cmpl_valid_in & cmpl_committed_in & ~cmpl_fault_in)
                         | (units_empty_in & restart_known_in));

    // priority: reset, machine check, oldest fault, then async
    always_comb begin
        take_kind = exord_pkg::EXORD_K_NONE;
        take_vec  = exord_pkg::VEC_BASE_RST;
        take_addr = restart_addr_in;
        if (rst_req_q) begin
            take_kind = exord_pkg::EXORD_K_RESET;
            take_vec  = exord_pkg::VEC_RESET;
        end else if (mc_req_q) begin
            take_kind = exord_pkg::EXORD_K_MC;
            take_vec  = exord_pkg::VEC_MCHECK;
        end else if (sync_fault) begin
            // float faults are precise in every mode
            take_kind = exord_pkg::EXORD_K_SYNC;
            take_vec  = cmpl_fault_vec_in;
            take_addr = cmpl_trap_in ? cmpl_next_addr_in : cmpl_addr_in;
        end else if (async_any && async_ok) begin
            take_addr = (cmpl_valid_in & cmpl_committed_in) ? cmpl_next_addr_in : restart_addr_in;
            if (smi_pend_q) begin
                take_kind = exord_pkg::EXORD_K_SMI;
                take_vec  = exord_pkg::VEC_SMI;
            end else if (ext_pend_q) begin
                take_kind = exord_pkg::EXORD_K_EXT;
                take_vec  = exord_pkg::VEC_EXT;
            end else begin
                take_kind = exord_pkg::EXORD_K_DECR;
                take_vec  = exord_pkg::VEC_DECR;
            end
        end
    end

    // reset and machine check may break in; others only from run
    assign take_now = (take_kind == exord_pkg::EXORD_K_RESET) | (take_kind == exord_pkg::EXORD_K_MC)
                      | ((take_kind != exord_pkg::EXORD_K_NONE) & (state_q == exord_pkg::EXORD_RUN));
    assign flush_younger_out = take_now;
    assign busy_out = (state_q != exord_pkg::EXORD_RUN);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= exord_pkg::EXORD_RUN;
        end else begin
            case (state_q)
                exord_pkg::EXORD_RUN: begin
                    if (take_now) begin
                        state_q <= exord_pkg::EXORD_HOLD;
                    end
                end
                exord_pkg::EXORD_HOLD: begin
                    if (!take_now && handler_done_in) begin
                        // next fault of the same instruction comes on its own
                        state_q <= cmpl_more_faults_in ? exord_pkg::EXORD_DRAIN
                                                       : exord_pkg::EXORD_RUN;
                    end
                end
                exord_pkg::EXORD_DRAIN: begin
                    state_q <= take_now ? exord_pkg::EXORD_HOLD
                                        : exord_pkg::EXORD_RUN;
                end
                default: begin
                    state_q <= exord_pkg::EXORD_RUN;
                end
            endcase
        end
    end

    // kind of the exception in progress, for recoverability
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            kind_q <= exord_pkg::EXORD_K_NONE;
        end else if (take_now) begin
            kind_q <= take_kind;
        end
    end

    // context save and redirect in one cycle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fetch_redirect_out         <= 1'b0;
            fetch_addr_out             <= exord_pkg::VEC_BASE_RST;
            save_restore_addr_reg_out  <= '0;
            save_restore_state_reg_out <= '0;
        end else begin
            fetch_redirect_out <= take_now;
            if (take_now) begin
                fetch_addr_out            <= take_vec;
                save_restore_addr_reg_out <= take_addr;
                save_restore_state_reg_out <= msr_out & exord_pkg::SAVE_RESTORE_STATE_REG_KEEP;
            end
        end
    end

    // supervisor state with interrupts off on take, else software write
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            msr_out <= exord_pkg::MSR_RESET;
        end else if (take_now) begin
            msr_out <= exord_pkg::MSR_RESET;
            // interrupted state not recoverable until software sets the bit again
            msr_out[exord_pkg::RECOVERABLE_INTERRUPT_BIT] <= 1'b0;
        end else if (msr_write_in) begin
            msr_out <= msr_wdata_in;
        end
    end

    assign recoverable_interrupt_bit_out = save_restore_state_reg_out[exord_pkg::RECOVERABLE_INTERRUPT_BIT]
                                           & (kind_q != exord_pkg::EXORD_K_RESET)
                                           & (kind_q != exord_pkg::EXORD_K_MC);
    logic fp_unused;
    assign fp_unused = fp_imprecise_mode_in;
endmodule

/* File: logic/exord_pkg.sv */
package exord_pkg;
    localparam int ADDR_W = 32;
    localparam int MSR_W  = 32;
    localparam int CAUSE_W = 4;
    localparam logic [ADDR_W-1:0] VEC_RESET   = 32'h0000_0100;
    localparam logic [ADDR_W-1:0] VEC_MCHECK  = 32'h0000_0200;
    localparam logic [ADDR_W-1:0] VEC_EXT     = 32'h0000_0500;
    localparam logic [ADDR_W-1:0] VEC_DECR    = 32'h0000_0900;
    localparam logic [ADDR_W-1:0] VEC_SMI     = 32'h0000_1400;
    localparam logic [ADDR_W-1:0] VEC_BASE_RST = 32'h0000_0000;
    localparam int HWC_MCP_EN = 0;
    localparam int HWC_APE_EN = 2;
    localparam int HWC_DPE_EN = 3;
    localparam int MSR_EE  = 15;
    localparam int MSR_PR  = 14;
    localparam int RECOVERABLE_INTERRUPT_BIT  = 1;
    localparam logic [MSR_W-1:0] MSR_RESET = 32'h0000_0000;
    localparam logic [MSR_W-1:0] SAVE_RESTORE_STATE_REG_KEEP = 32'h0000_FFFF;
    localparam int MC_TEA = 0;
    localparam int MC_MCP = 1;
    localparam int MC_APE = 2;
    localparam int MC_DPE = 3;
    localparam int SYNC_STAGES = 3;
    typedef enum logic [2:0] {
        EXORD_RUN   = 3'b000,
        EXORD_DRAIN = 3'b001,
        EXORD_TAKE  = 3'b010,
        EXORD_HOLD  = 3'b011
    } exord_state_t;
    typedef enum logic [2:0] {
        EXORD_K_NONE  = 3'b000,
        EXORD_K_RESET = 3'b001,
        EXORD_K_MC    = 3'b010,
        EXORD_K_SYNC  = 3'b011,
        EXORD_K_EXT   = 3'b100,
        EXORD_K_DECR  = 3'b101,
        EXORD_K_SMI   = 3'b110
    } exord_kind_t;
endpackage

/* File: logic/exord_sync.sv */
`timescale 1ns/1ps
module exord_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    // three stages, level accepted when stage 2 and 3 agree
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge ref_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    level_out[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    level_out[i] <= s3_q[i];
                end
            end
        end
    endgenerate
endmodule

/* File: verification/exord_ctrl_assertions.sv */
`timescale 1ns/1ps
module exord_ctrl_assertions #(
    parameter int ADDR_W = 32,
    parameter int MSR_W  = 32
) (
    input wire logic              ref_clk_in,
    input wire logic              rst_in,
    input wire logic              soft_reset_in,
    input wire logic              hard_reset_in,
    input wire logic              bus_transfer_error_in,
    input wire logic [3:0]        hw_config_reg_in,
    input wire logic [2:0]        src_enable_in,
    input wire logic              cmpl_committed_in,
    input wire logic              cmpl_fault_in,
    input wire logic              cmpl_trap_in,
    input wire logic [ADDR_W-1:0] cmpl_addr_in,
    input wire logic [ADDR_W-1:0] cmpl_fault_vec_in,
    input wire logic              store_queue_empty_in,
    input wire logic              cmpl_accept_out,
    input wire logic              flush_younger_out,
    input wire logic              fetch_redirect_out,
    input wire logic [ADDR_W-1:0] fetch_addr_out,
    input wire logic [ADDR_W-1:0] save_restore_addr_reg_out,
    input wire logic [MSR_W-1:0]  msr_out,
    input wire logic [3:0]        mcheck_cause_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    retire_commit_a: assert property (cmpl_accept_out |-> cmpl_committed_in)
        else $error("retire before commit");
    take_redirect_a: assert property (flush_younger_out |=> fetch_redirect_out)
        else $error("take without redirect");
    supervisor_entry_a: assert property (fetch_redirect_out |-> !msr_out[exord_pkg::MSR_PR])
        else $error("no supervisor state on take");
    fault_addr_a: assert property (fetch_redirect_out && $past(cmpl_fault_in) &&
        !$past(cmpl_trap_in) && fetch_addr_out == $past(cmpl_fault_vec_in) |->
        save_restore_addr_reg_out == $past(cmpl_addr_in))
        else $error("faulting address not saved");
    tea_mcheck_a: assert property ($rose(bus_transfer_error_in) |-> ##[1:12]
        (fetch_redirect_out && fetch_addr_out == exord_pkg::VEC_MCHECK))
        else $error("transfer error gave no machine check");
    reset_vector_a: assert property ($rose(soft_reset_in) || $rose(hard_reset_in) |-> ##[1:12]
        (fetch_redirect_out && fetch_addr_out == exord_pkg::VEC_RESET))
        else $error("reset pin gave no reset vector");
    mask_gate_a: assert property (($rose(mcheck_cause_out[exord_pkg::MC_APE]) |->
        $past(hw_config_reg_in[exord_pkg::HWC_APE_EN])) and ($rose(mcheck_cause_out[exord_pkg::MC_MCP]) |->
        $past(hw_config_reg_in[exord_pkg::HWC_MCP_EN])))
        else $error("masked source raised machine check");
    irq_gate_a: assert property (fetch_redirect_out && fetch_addr_out == exord_pkg::VEC_EXT |->
        $past(msr_out[exord_pkg::MSR_EE]) && $past(src_enable_in[0]) && $past(store_queue_empty_in))
        else $error("interrupt taken while masked or stores pending");
endmodule

bind exord_ctrl exord_ctrl_assertions #(.ADDR_W(ADDR_W), .MSR_W(MSR_W)) CHK (.*);

/* File: verification/exord_pipe_model.sv */
`timescale 1ns/1ps
module exord_pipe_model (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        issue_in,
    input  wire logic        fault_in,
    input  wire logic [31:0] addr_in,
    input  wire logic        accept_in,
    input  wire logic        flush_in,
    output logic             valid_out,
    output logic             committed_out,
    output logic             fault_out,
    output logic [31:0]      addr_out,
    output logic             sq_empty_out
);
    logic        fault_q;
    logic [31:0] addr_q;
    logic [1:0]  sq_q;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
            committed_out <= 1'b0;
            fault_q <= 1'b0;
            addr_q <= 32'h0;
            sq_q <= 2'h0;
        end else begin
            if (issue_in) begin
                valid_out <= 1'b1;
                fault_q <= fault_in;
                addr_q <= addr_in;
            end else if (accept_in || flush_in) begin
                valid_out <= 1'b0;
            end
            // results reach the architected file a cycle after the slot fills
            committed_out <= valid_out && !accept_in && !flush_in && !issue_in;
            sq_q <= accept_in ? 2'h3 : (sq_q == 2'h0 ? 2'h0 : sq_q - 2'h1);
        end
    end
    // released slot shows the inverse of its last contents
    assign fault_out = valid_out ? fault_q : ~fault_q;
    assign addr_out = valid_out ? addr_q : ~addr_q;
    assign sq_empty_out = (sq_q == 2'h0);
endmodule

/* File: verification/tb_exception_ordering_control.sv */
`timescale 1ns/1ps
module tb_exception_ordering_control;
    localparam logic [31:0] IRQ_VEC [3] = '{exord_pkg::VEC_EXT, exord_pkg::VEC_DECR, exord_pkg::VEC_SMI};
    logic        ref_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [1:0]  rs = 2'h0;
    logic [3:0]  mc = 4'h0;
    logic [2:0]  irq = 3'h0;
    logic [3:0]  hw_config_reg_in = 4'h0;
    logic [2:0]  src_enable_in = 3'h0;
    logic        fp_imprecise_mode_in = 1'b0;
    logic        older_pending_in = 1'b0;
    logic        units_empty_in = 1'b1;
    logic        restart_known_in = 1'b1;
    logic        handler_done_in = 1'b0;
    logic        msr_write_in = 1'b0;
    logic        issue = 1'b0;
    logic        issue_fault = 1'b0;
    logic        cmpl_more_faults_in = 1'b0;
    logic        cmpl_trap_in = 1'b0;
    logic [31:0] issue_addr = 32'h0;
    logic [31:0] msr_wdata_in = 32'h0;
    logic [31:0] restart_addr_in = 32'h0;
    logic [31:0] cmpl_fault_vec_in = 32'h0000_0700;
    logic [31:0] cmpl_next_addr_in = 32'h0;
    logic        cmpl_valid_in, cmpl_committed_in, cmpl_fault_in, store_queue_empty_in;
    logic        cmpl_accept_out, flush_younger_out, fetch_redirect_out, recoverable_interrupt_bit_out, busy_out;
    logic [31:0] cmpl_addr_in, fetch_addr_out, save_restore_addr_reg_out, save_restore_state_reg_out, msr_out;
    logic [3:0]  mcheck_cause_out;
    int          num_errors = 0;
    int          checks = 0;
    wire soft_reset_in = rs[0], hard_reset_in = rs[1];
    wire bus_transfer_error_in = mc[0], machine_check_request_in = mc[1];
    wire address_parity_error_in = mc[2], data_parity_error_in = mc[3];
    wire ext_irq_in = irq[0], decrementer_irq_in = irq[1], system_management_irq_in = irq[2];

    always #5 ref_clk_in = ~ref_clk_in;

    exord_ctrl DUT (.*);
    exord_pipe_model PIPE (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .issue_in(issue), .fault_in(issue_fault),
        .addr_in(issue_addr), .accept_in(cmpl_accept_out), .flush_in(flush_younger_out), .valid_out(cmpl_valid_in),
        .committed_out(cmpl_committed_in), .fault_out(cmpl_fault_in), .addr_out(cmpl_addr_in),
        .sq_empty_out(store_queue_empty_in));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic expect_take(input logic [31:0] vec, input logic want);
        int n;
        n = 0;
        while (fetch_redirect_out !== 1'b1 && n < 12) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk({31'h0, fetch_redirect_out === 1'b1}, {31'h0, want}, "take");
        if (want) begin
            chk(fetch_addr_out, vec, "vector");
        end
    endtask

    task automatic wr_msr(input logic [31:0] v);
        msr_write_in = 1'b1;
        msr_wdata_in = v;
        @(negedge ref_clk_in);
        msr_write_in = 1'b0;
    endtask

    task automatic handler();
        @(negedge ref_clk_in);
        handler_done_in = 1'b1;
        @(negedge ref_clk_in);
        handler_done_in = 1'b0;
        repeat (6) @(negedge ref_clk_in);
    endtask

    task automatic send(input logic f, input logic [31:0] a);
        issue = 1'b1;
        issue_fault = f;
        issue_addr = a;
        @(negedge ref_clk_in);
        issue = 1'b0;
        repeat (4) @(negedge ref_clk_in);
    endtask

    initial begin
        repeat (12) @(negedge ref_clk_in);
        rst_in = 1'b0;
        @(negedge ref_clk_in);
        chk({31'h0, recoverable_interrupt_bit_out}, 32'h0, "ri reset");
        wr_msr(32'h0000_4002);
        chk({31'h0, msr_out[exord_pkg::RECOVERABLE_INTERRUPT_BIT]}, 32'h1, "ri set");
        units_empty_in = 1'b0;
        send(1'b0, 32'h0000_1FFC);
        chk({31'h0, cmpl_valid_in}, 32'h0, "retired");
        fp_imprecise_mode_in = 1'b1;
        older_pending_in = 1'b1;
        send(1'b1, 32'h0000_2000);
        expect_take(cmpl_fault_vec_in, 1'b0);
        older_pending_in = 1'b0;
        expect_take(cmpl_fault_vec_in, 1'b1);
        chk(save_restore_addr_reg_out, 32'h0000_2000, "save_restore_addr_reg fault");
        chk(save_restore_state_reg_out, 32'h0000_4002, "save_restore_state_reg fault");
        chk({31'h0, msr_out[exord_pkg::MSR_PR]}, 32'h0, "supervisor");
        chk({31'h0, busy_out}, 32'h1, "busy");
        chk({31'h0, recoverable_interrupt_bit_out}, 32'h1, "ri fault");
        handler();
        cmpl_trap_in = 1'b1;
        cmpl_more_faults_in = 1'b1;
        cmpl_next_addr_in = 32'h0000_2004;
        issue = 1'b1;
        issue_addr = 32'h0000_2000;
        @(negedge ref_clk_in);
        issue = 1'b0;
        expect_take(cmpl_fault_vec_in, 1'b1);
        chk(save_restore_addr_reg_out, 32'h0000_2004, "save_restore_addr_reg trap");
        @(negedge ref_clk_in);
        handler_done_in = 1'b1;
        @(negedge ref_clk_in);
        handler_done_in = 1'b0;
        chk({31'h0, busy_out}, 32'h1, "drain");
        @(negedge ref_clk_in);
        chk({31'h0, busy_out}, 32'h0, "run");
        cmpl_trap_in = 1'b0;
        cmpl_more_faults_in = 1'b0;
        fp_imprecise_mode_in = 1'b0;
        units_empty_in = 1'b1;
        src_enable_in = 3'h1;
        irq[0] = 1'b1;
        expect_take(exord_pkg::VEC_EXT, 1'b0);
        for (int i = 0; i < 3; i++) begin
            src_enable_in = 3'(1 << i);
            irq[i] = 1'b1;
            restart_addr_in = 32'h0000_3000 + 32'(i * 4);
            wr_msr(32'h0000_8002);
            expect_take(IRQ_VEC[i], 1'b1);
            irq[i] = 1'b0;
            chk(save_restore_addr_reg_out, restart_addr_in, "save_restore_addr_reg idle");
            chk(save_restore_state_reg_out, 32'h0000_8002, "save_restore_state_reg irq");
            chk({31'h0, recoverable_interrupt_bit_out}, 32'h1, "ri irq");
            handler();
        end
        src_enable_in = 3'h0;
        wr_msr(32'h0000_0002);
        for (int j = 0; j < 8; j++) begin
            hw_config_reg_in = (j < 4) ? 4'h0 : 4'hD;
            mc[j % 4] = 1'b1;
            expect_take(exord_pkg::VEC_MCHECK, j == 0 || j >= 4);
            mc[j % 4] = 1'b0;
            @(negedge ref_clk_in);
            if (j == 0 || j >= 4) begin
                chk({28'h0, mcheck_cause_out}, 32'h1 << (j % 4), "cause");
                chk({31'h0, recoverable_interrupt_bit_out}, 32'h0, "ri mcheck");
                handler();
            end
            repeat (6) @(negedge ref_clk_in);
        end
        for (int k = 0; k < 2; k++) begin
            rs[k] = 1'b1;
            expect_take(exord_pkg::VEC_RESET, 1'b1);
            rs[k] = 1'b0;
            handler();
        end
        give_verdict();
    end

    // several times the expected run length
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
endmodule
